// file: inc/iowdt_defines.vh
/*
 holds the offsets, field positions, reset values and timing counts of the
 port-mapped system watchdog.
 assumes an isa-style byte-wide i/o cycle and a 125 mhz system clock.
*/
//
// Behaviour
// R1 - one port address is decoded and a write there loads the control byte.
// R2 - a port read clears the counter so it restarts from the full interval.
// R3 - while on, the counter steps down each second and a refresh reloads it.
// R4 - reaching zero with no refresh drives a reset out to the system.
// R5 - control bit 3 enables counting and timeout reset; zero disables all.
// R6 - control bits 2 to 0 pick one of eight intervals; code 000 means 64 s.
// R7 - power-up or system reset leaves the control byte all zero.
// R8 - a newly written control byte takes effect at once; a write during the reset pulse only applies once the pulse ends.
// R9 - software reads the port before enabling and keeps refreshing in time.
// R10 - bits 7 to 4 are ignored and codes 1 to 7 give 1,2,4,8,16,32,128 s.
// R11 - a prescaler makes a one-second tick that steps the counter once.
`ifndef IOWDT_DEFINES_VH
`define IOWDT_DEFINES_VH

// -------------------------------------------------
// port and fields
// -------------------------------------------------
`define IOWDT_PORT_ADDR 16'h00F2
`define IOWDT_CTRL_RESET 4'h0
`define IOWDT_EN_BIT 3
`define IOWDT_SEL_MSB 2
`define IOWDT_SEL_LSB 0

// -------------------------------------------------
// timing
// -------------------------------------------------
`define IOWDT_CLK_HZ 125000000
`define IOWDT_TICK_SEC 1
`define IOWDT_TICK_CYC (`IOWDT_CLK_HZ * `IOWDT_TICK_SEC)
`define IOWDT_SEL_DEFAULT_SEC 8'h40
`define IOWDT_SEL_MAX_SEC 8'h80
`define IOWDT_RST_PULSE_CYC 16

`endif

// file: hdl/iowdt_tick.v
/*
 one-second tick prescaler for the watchdog.
 assumes a free-running system clock; restart clears the phase.
*/
`include "iowdt_defines.vh"

module iowdt_tick #(
   parameter TICK_CYC = `IOWDT_TICK_CYC
) (
   input wire i_clk,
   input wire i_arst_n,
   input wire i_restart,
   output reg o_tick
);

   reg [31:0] cnt_r;

   // -------------------------------------------------
   // prescaler
   // -------------------------------------------------
   // R11 one-second tick
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r <= 32'h00000000;
         o_tick <= 1'b0;
      end else if (i_restart) begin
         cnt_r <= 32'h00000000;
         o_tick <= 1'b0;
      end else if (cnt_r == TICK_CYC - 1) begin
         cnt_r <= 32'h00000000;
         o_tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h00000001;
         o_tick <= 1'b0;
      end
   end

endmodule // iowdt_tick

// file: hdl/iowdt_top.v
/*
 port-mapped system watchdog: control byte, seconds countdown, reset out.
 assumes i/o strobes are synchronous one-cycle pulses on i_clk.
*/
`include "iowdt_defines.vh"

module iowdt_top #(
   parameter TICK_CYC = `IOWDT_TICK_CYC,
   parameter PORT_ADDR = `IOWDT_PORT_ADDR,
   parameter RST_PULSE_CYC = `IOWDT_RST_PULSE_CYC
) (
   input wire i_clk,
   input wire i_arst_n,
   input wire [15:0] i_io_addr,
   input wire i_io_wr,
   input wire i_io_rd,
   input wire [7:0] i_io_wdata,
   output reg [7:0] o_io_rdata,
   output reg o_io_rvalid,
   output reg o_sys_reset,
   output reg [7:0] o_count
);

   localparam ST_IDLE = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_FIRE = 3'b100;

   reg [3:0] ctrl_r;
   reg [7:0] count_r;
   reg [7:0] count_nxt;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [4:0] pulse_r;
   reg [4:0] pulse_nxt;
   wire hit;
   wire wr_hit;
   wire rd_hit;
   wire tick;
   wire enable;

   // -------------------------------------------------
   // interval decode
   // -------------------------------------------------
   // R6 R10 interval map
   function [7:0] sel_seconds;
      input [2:0] sel;
      begin
         case (sel)
            3'h0: sel_seconds = `IOWDT_SEL_DEFAULT_SEC;
            3'h7: sel_seconds = `IOWDT_SEL_MAX_SEC;
            default: sel_seconds = 8'h01 << sel[2:0] >> 1;
         endcase
      end
   endfunction

   // R1 single address decode
   assign hit = (i_io_addr == PORT_ADDR);
   assign wr_hit = hit & i_io_wr;
   assign rd_hit = hit & i_io_rd;
   // R5 enable gate
   assign enable = ctrl_r[`IOWDT_EN_BIT];

   iowdt_tick #(
      .TICK_CYC(TICK_CYC)
   ) u_tick (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_restart(rd_hit | wr_hit),
      .o_tick(tick)
   );

   // -------------------------------------------------
   // control register
   // -------------------------------------------------
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         // R7 cleared control
         ctrl_r <= `IOWDT_CTRL_RESET;
      end else if (wr_hit) begin
         // R1 R10 load low nibble
         ctrl_r <= i_io_wdata[3:0];
      end
   end

   // -------------------------------------------------
   // expiry decode
   // -------------------------------------------------
   localparam [4:0] PULSE_LOAD = RST_PULSE_CYC[4:0];
   wire expire;

   // R4 last second gone
   assign expire = (state_r == ST_RUN) & enable & ~rd_hit & tick &
      (count_r == 8'h01);

   // -------------------------------------------------
   // next state
   // -------------------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (enable) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!enable) begin
               state_nxt = ST_IDLE;
            end else if (expire) begin
               // R4 timeout reset
               state_nxt = ST_FIRE;
            end
         end
         ST_FIRE: begin
            if (pulse_r == 5'h01) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // R8 new settings apply
      if (wr_hit && state_r != ST_FIRE) begin
         state_nxt = i_io_wdata[`IOWDT_EN_BIT] ? ST_RUN : ST_IDLE;
      end
   end

   // -------------------------------------------------
   // next count
   // -------------------------------------------------
   always @* begin
      count_nxt = count_r;
      case (state_r)
         ST_IDLE: begin
            count_nxt = sel_seconds(ctrl_r[`IOWDT_SEL_MSB:`IOWDT_SEL_LSB]);
         end
         ST_RUN: begin
            if (!enable) begin
               count_nxt = count_r;
            end else if (rd_hit) begin
               // R2 R3 refresh reload
               count_nxt = sel_seconds(ctrl_r[`IOWDT_SEL_MSB:`IOWDT_SEL_LSB]);
            end else if (tick) begin
               // R3 step down
               count_nxt = count_r - 8'h01;
            end
         end
         ST_FIRE: begin
            count_nxt = count_r;
         end
         default: begin
            count_nxt = count_r;
         end
      endcase
      // R8 new interval loads
      if (wr_hit && state_r != ST_FIRE) begin
         count_nxt = sel_seconds(i_io_wdata[`IOWDT_SEL_MSB:`IOWDT_SEL_LSB]);
      end
   end

   // -------------------------------------------------
   // pulse counter
   // -------------------------------------------------
   always @* begin
      pulse_nxt = pulse_r;
      case (state_r)
         ST_RUN: begin
            if (expire) begin
               // R4 pulse length load
               pulse_nxt = PULSE_LOAD;
            end
         end
         ST_FIRE: begin
            pulse_nxt = pulse_r - 5'h01;
         end
         default: begin
            pulse_nxt = pulse_r;
         end
      endcase
   end

   // -------------------------------------------------
   // state registers
   // -------------------------------------------------
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= ST_IDLE;
         count_r <= `IOWDT_SEL_DEFAULT_SEC;
         pulse_r <= 5'h00;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   // -------------------------------------------------
   // reset output
   // -------------------------------------------------
   // R4 reset to system
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sys_reset <= 1'b0;
      end else begin
         o_sys_reset <= (state_nxt == ST_FIRE);
      end
   end

   // -------------------------------------------------
   // count output
   // -------------------------------------------------
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_count <= 8'h00;
      end else begin
         o_count <= count_nxt;
      end
   end

   // -------------------------------------------------
   // read answer
   // -------------------------------------------------
   // R1 R10 read returns control
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_io_rvalid <= 1'b0;
         o_io_rdata <= 8'h00;
      end else begin
         o_io_rvalid <= rd_hit;
         o_io_rdata <= rd_hit ? {4'h0, ctrl_r} : 8'h00;
      end
   end

endmodule // iowdt_top

// file: testbench/iowdt_monitor.sv
/* port watchdog checker.
   sees only the top ports; bound below. */
module iowdt_monitor #(
   parameter TICK_CYC = 16,
   parameter PORT_ADDR = 16'h00F2,
   parameter RST_PULSE_CYC = 16
) (
   input wire i_clk,
   input wire i_arst_n,
   input wire [15:0] i_io_addr,
   input wire i_io_wr,
   input wire i_io_rd,
   input wire [7:0] i_io_wdata,
   input wire [7:0] o_io_rdata,
   input wire o_io_rvalid,
   input wire o_sys_reset,
   input wire [7:0] o_count
);
   // ----
   // shadow state
   // ----
   wire hit = i_io_addr == PORT_ADDR;
   reg [3:0] ctl_r;
   reg [7:0] hi_r;
   function automatic [7:0] ivl(input [2:0] s);
      ivl = s == 3'h0 ? 8'h40 : s == 3'h7 ? 8'h80 : 8'h01 << (s - 3'h1);
   endfunction
   always @(posedge i_clk or negedge i_arst_n)
      if (!i_arst_n) begin
         ctl_r <= 4'h0;
         hi_r <= 8'h00;
      end else begin
         if (hit && i_io_wr) ctl_r <= i_io_wdata[3:0];
         hi_r <= o_sys_reset ? hi_r + 8'h01 : 8'h00;
      end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   a_read_answered: assert property (hit && i_io_rd |=> o_io_rvalid)
      else $error("no read answer");
   a_no_stray: assert property (!(hit && i_io_rd) |=> !o_io_rvalid)
      else $error("stray read answer");
   a_rdata_ctrl: assert property (o_io_rvalid
      |-> o_io_rdata == {4'h0, $past(ctl_r)}) else $error("bad read data");
   a_write_loads: assert property (hit && i_io_wr && i_io_wdata[3]
      && !o_sys_reset |=> o_count == ivl(ctl_r[2:0])) else $error("bad load");
   a_read_reload: assert property (hit && i_io_rd && !i_io_wr && ctl_r[3]
      && !o_sys_reset && o_count != 8'h01 |=> o_count == ivl(ctl_r[2:0]))
      else $error("no reload");
   a_off_quiet: assert property (!ctl_r[3] && !$past(ctl_r[3])
      |-> !$rose(o_sys_reset)) else $error("reset while off");
   a_pulse_len: assert property ($fell(o_sys_reset) |-> hi_r == RST_PULSE_CYC)
      else $error("bad pulse length");
   a_zero_cause: assert property ($rose(o_sys_reset)
      |-> o_count == 8'h00 && $past(o_count) == 8'h01) else $error("bad cause");
   a_step_one: assert property (!$past(hit) && $past(o_count) > 8'h01
      && o_count < $past(o_count) |-> o_count == $past(o_count) - 8'h01)
      else $error("bad step");
   c_fire: cover property ($rose(o_sys_reset));
   c_read: cover property (o_io_rvalid);
   c_arm: cover property (hit && i_io_wr && i_io_wdata[3]);
endmodule // iowdt_monitor
bind iowdt_top iowdt_monitor #(.TICK_CYC(TICK_CYC), .PORT_ADDR(PORT_ADDR),
   .RST_PULSE_CYC(RST_PULSE_CYC)) mon_u (.i_clk, .i_arst_n, .i_io_addr,
   .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata, .o_io_rvalid, .o_sys_reset,
   .o_count);

// file: testbench/io_port_watchdog_timer_tb_top.sv
/* self-checking bench for the port watchdog.
   drives the i/o strobes itself; short tick keeps the run brief. */
`include "iowdt_defines.vh"
module io_port_watchdog_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // bench
   // ----
   localparam int T = 16;
   logic i_clk = 1'b0, i_arst_n = 1'b0, i_io_wr = 1'b0, i_io_rd = 1'b0;
   logic [15:0] i_io_addr = 16'h0000;
   logic [7:0] i_io_wdata = 8'h00, o_io_rdata, o_count;
   logic o_io_rvalid, o_sys_reset;
   logic [31:0] lf = 32'h1B18, r;
   int miscompares = 0, comparisons = 0, k;
   iowdt_top #(.TICK_CYC(T)) dut_u (.i_clk, .i_arst_n, .i_io_addr, .i_io_wr,
      .i_io_rd, .i_io_wdata, .o_io_rdata, .o_io_rvalid, .o_sys_reset, .o_count);
   initial forever #4 i_clk = ~i_clk;
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction
   function automatic logic [7:0] ivl(input logic [2:0] s);
      return s == 3'h0 ? 8'h40 : s == 3'h7 ? 8'h80 : 8'h01 << (s - 3'h1);
   endfunction
   task automatic chk_rd(input logic [8:0] g, e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: read %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_cnt(input logic [7:0] g, e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: count %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_cyc(input int g, lo, hi);
      comparisons++;
      if (g < lo || g > hi) begin
         miscompares++;
         $display("wrong value at %0t: cycles %0d want %0d..%0d", $time, g,
            lo, hi);
      end
   endtask
   task automatic io(input logic w, rd, input logic [15:0] a,
      input logic [7:0] d);
      @(posedge i_clk);
      i_io_wr <= w;
      i_io_rd <= rd;
      i_io_addr <= a;
      i_io_wdata <= d;
      @(posedge i_clk);
      i_io_wr <= 1'b0;
      i_io_rd <= 1'b0;
      #1;
   endtask
   task automatic summarize();
      if (miscompares == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge i_clk);
      i_arst_n <= 1'b1;
      io(1'b0, 1'b1, `IOWDT_PORT_ADDR, 8'h00);
      chk_rd({o_io_rvalid, o_io_rdata}, 9'h100);
      chk_cnt(o_count, 8'h40);
      for (int c = 0; c < 8; c++) begin
         r = rnd();
         io(1'b0, 1'b1, `IOWDT_PORT_ADDR, 8'h00);
         io(1'b1, 1'b0, `IOWDT_PORT_ADDR, {r[7:4], 1'b1, c[2:0]});
         chk_cnt(o_count, ivl(c[2:0]));
         io(1'b1, 1'b0, r[15:0] | 16'h0100, 8'h00);
         io(1'b0, 1'b1, `IOWDT_PORT_ADDR, 8'h00);
         chk_rd({o_io_rvalid, o_io_rdata}, {1'b1, 4'h0, 1'b1, c[2:0]});
         chk_cnt(o_count, ivl(c[2:0]));
         repeat (r[23:16] % 8) @(posedge i_clk);
         io(1'b0, 1'b1, `IOWDT_PORT_ADDR, 8'h00);
         k = 0;
         while (o_sys_reset !== 1'b1 && k < 3000) begin
            @(posedge i_clk);
            #1;
            k++;
         end
         chk_cyc(k, ivl(c[2:0]) * T - 3, ivl(c[2:0]) * T + 1);
         k = 0;
         while (o_sys_reset === 1'b1 && k < 40) begin
            @(posedge i_clk);
            #1;
            k++;
         end
         chk_cyc(k, `IOWDT_RST_PULSE_CYC, `IOWDT_RST_PULSE_CYC);
      end
      io(1'b1, 1'b0, `IOWDT_PORT_ADDR, 8'h01);
      k = 0;
      repeat (40) begin
         @(posedge i_clk);
         #1;
         k += (o_sys_reset !== 1'b0);
      end
      chk_cyc(k, 0, 0);
      @(posedge i_clk);
      i_arst_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      io(1'b0, 1'b1, `IOWDT_PORT_ADDR, 8'h00);
      chk_rd({o_io_rvalid, o_io_rdata}, 9'h100);
      chk_cnt(o_count, 8'h40);
      summarize();
   end
   initial begin
      #100000;
      miscompares++;
      summarize();
   end
endmodule // io_port_watchdog_timer_tb_top
